/* core/irq_prio_pkg.sv */
// What this block does
// - priority bit one means high, zero low
// - second priority register layout, unused bits zero
// - third priority register holds bus-controller priorities
// - edge select picks rising or falling edge
// - valid edge sets external flag
// - cleared enable blocks external request
// - external interrupts enabled as sleep began wake from sleep
// - wake vectors only with global enable
// - external one to three follow priority bits
// - external zero always high priority
// - 8-bit timer rollover sets timer flag
// - 16-bit timer rollover sets timer flag
// - timer interrupt gated and prioritised
// - port-B upper pins change sets flag
// - port-change interrupt gated and prioritised
// - entry pushes return counter onto stack
// - entry copies working, status, bank to shadow
package irq_prio_pkg;
  // register indices on the plain port
  localparam logic [3:0] ADDR_CTRL_MAIN = 4'h0;
  localparam logic [3:0] ADDR_CTRL_SECOND = 4'h1;
  localparam logic [3:0] ADDR_CTRL_THIRD = 4'h2;
  localparam logic [3:0] ADDR_PRIO_ONE = 4'h3;
  localparam logic [3:0] ADDR_PRIO_TWO = 4'h4;
  localparam logic [3:0] ADDR_BUS_PRIO = 4'h5;
  localparam logic [3:0] ADDR_PERIPH_FLAG = 4'h6;
  localparam logic [3:0] ADDR_PERIPH_EN = 4'h7;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  // main control fields
  localparam int MAIN_GIE = 7;
  localparam int MAIN_T0IE = 5;
  localparam int MAIN_E0IE = 4;
  localparam int MAIN_PORT_CHANGE_ENABLE = 3;
  localparam int MAIN_T0IF = 2;
  localparam int MAIN_E0IF = 1;
  localparam int MAIN_PORT_CHANGE_FLAG = 0;
  // second control fields: edge selects 7:4, priorities
  localparam int SEC_EDGE_LO = 4;
  localparam int SEC_E2IP = 3;
  localparam int SEC_T0IP = 2;
  localparam int SEC_PORT_CHANGE_PRIO = 0;
  // third control fields
  localparam int THR_E1IP = 7;
  localparam int THR_E3IP = 6;
  localparam int THR_IE_LO = 3;
  localparam int THR_IF_LO = 0;
  // writable mask of second priority register
  localparam logic [7:0] PRIO_TWO_MASK = 8'h4f;
  // reset values
  localparam logic [7:0] RST_CTRL_MAIN = 8'h00;
  localparam logic [7:0] RST_CTRL_SECOND = 8'hf5;
  localparam logic [7:0] RST_CTRL_THIRD = 8'hc0;
  localparam logic [7:0] RST_PRIO = 8'hff;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // counts and widths
  localparam int N_EXT = 4;
  localparam int N_PERIPH = 24;
  localparam logic [15:0] T0_WRAP16 = 16'hffff;
  localparam logic [7:0] T0_WRAP8 = 8'hff;

  typedef struct packed {
    logic [7:0] w;
    logic [7:0] status;
    logic [7:0] bank;
  } context_s;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;
endpackage

/* core/irq_prio.sv */
// The implementer's own choices: the strobed register port and the register addresses.
module irq_prio (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // register port
  input wire irq_prio_pkg::reg_req_s req,
  output logic [7:0] rdata,
  // event sources
  input wire logic [3:0] ext_pins,
  input wire logic [3:0] port_b_pins,
  input wire logic [15:0] timer_zero_count_pair,
  input wire logic timer_zero_tick,
  input wire logic timer_zero_16bit,
  input wire logic [23:0] periph_flags_set,
  // core side
  input wire logic sleeping,
  input wire logic irq_ack,
  input wire logic [20:0] return_pc,
  input wire irq_prio_pkg::context_s core_context,
  output logic irq_high,
  output logic irq_low,
  output logic wake,
  output logic [20:0] stack_top,
  output logic [4:0] stack_depth,
  output irq_prio_pkg::context_s shadow_context
);
  localparam int DEPTH = 31;

  logic [7:0] ctrl_main_r, ctrl_main_nxt;
  logic [7:0] ctrl_second_r, ctrl_second_nxt;
  logic [7:0] ctrl_third_r, ctrl_third_nxt;
  logic [7:0] periph_irq_priority_one_r, periph_irq_priority_one_nxt;
  logic [7:0] periph_irq_priority_two_r, periph_irq_priority_two_nxt;
  logic [7:0] bus_ctrl_irq_priority_r, bus_ctrl_irq_priority_nxt;
  logic [23:0] periph_flag_r, periph_flag_nxt;
  logic [23:0] periph_en_r, periph_en_nxt;
  logic [3:0] ext_prev_r, ext_prev_nxt;
  logic [3:0] port_b_pins_prev_r, port_b_pins_prev_nxt;
  logic [3:0] armed_r, armed_nxt;
  logic sleep_prev_r;
  logic [7:0] rdata_nxt;
  logic [3:0] ext_edge;
  logic [3:0] ext_flag;
  logic [3:0] ext_en;
  logic [3:0] ext_prio;
  logic t0_wrap;
  logic port_b_pins_change;
  logic [23:0] periph_prio;
  logic [23:0] periph_req;
  logic any_high, any_low;
  logic wr_main, wr_second, wr_third;

  // stack storage
  logic [20:0] stack_mem [DEPTH];
  logic [4:0] depth_r, depth_nxt;
  irq_prio_pkg::context_s shadow_r, shadow_nxt;

  assign wr_main = req.wr && req.addr == irq_prio_pkg::ADDR_CTRL_MAIN;
  assign wr_second = req.wr && req.addr == irq_prio_pkg::ADDR_CTRL_SECOND;
  assign wr_third = req.wr && req.addr == irq_prio_pkg::ADDR_CTRL_THIRD;

  // external edge detection with per-pin polarity
  always_comb begin
    for (int i = 0; i < irq_prio_pkg::N_EXT; i++) begin
      if (ctrl_second_r[irq_prio_pkg::SEC_EDGE_LO + i]) begin
        ext_edge[i] = ext_pins[i] && !ext_prev_r[i];
      end else begin
        ext_edge[i] = !ext_pins[i] && ext_prev_r[i];
      end
    end
  end

  // timer rollover and port change detection
  always_comb begin
    if (timer_zero_16bit) begin
      t0_wrap = timer_zero_tick &&
        timer_zero_count_pair == irq_prio_pkg::T0_WRAP16;
    end else begin
      t0_wrap = timer_zero_tick &&
        timer_zero_count_pair[7:0] == irq_prio_pkg::T0_WRAP8;
    end
    port_b_pins_change = |(port_b_pins ^ port_b_pins_prev_r);
  end

  // gather external flags, enables and priorities
  always_comb begin
    ext_flag = {ctrl_third_r[irq_prio_pkg::THR_IF_LO + 2],
      ctrl_third_r[irq_prio_pkg::THR_IF_LO + 1],
      ctrl_third_r[irq_prio_pkg::THR_IF_LO],
      ctrl_main_r[irq_prio_pkg::MAIN_E0IF]};
    ext_en = {ctrl_third_r[irq_prio_pkg::THR_IE_LO + 2],
      ctrl_third_r[irq_prio_pkg::THR_IE_LO + 1],
      ctrl_third_r[irq_prio_pkg::THR_IE_LO],
      ctrl_main_r[irq_prio_pkg::MAIN_E0IE]};
    ext_prio = {ctrl_third_r[irq_prio_pkg::THR_E3IP],
      ctrl_second_r[irq_prio_pkg::SEC_E2IP],
      ctrl_third_r[irq_prio_pkg::THR_E1IP],
      1'b1};
    periph_prio = {bus_ctrl_irq_priority_r,
      periph_irq_priority_two_r & irq_prio_pkg::PRIO_TWO_MASK,
      periph_irq_priority_one_r};
  end

  // request merge by priority
  always_comb begin
    logic t0_req;
    logic rb_req;
    logic t0_hi;
    logic rb_hi;
    t0_req = ctrl_main_r[irq_prio_pkg::MAIN_T0IF] &&
      ctrl_main_r[irq_prio_pkg::MAIN_T0IE];
    rb_req = ctrl_main_r[irq_prio_pkg::MAIN_PORT_CHANGE_FLAG] &&
      ctrl_main_r[irq_prio_pkg::MAIN_PORT_CHANGE_ENABLE];
    t0_hi = ctrl_second_r[irq_prio_pkg::SEC_T0IP];
    rb_hi = ctrl_second_r[irq_prio_pkg::SEC_PORT_CHANGE_PRIO];
    periph_req = periph_flag_r & periph_en_r;
    any_high = |(ext_flag & ext_en & ext_prio) ||
      (t0_req && t0_hi) || (rb_req && rb_hi) ||
      |(periph_req & periph_prio);
    any_low = |(ext_flag & ext_en & ~ext_prio) ||
      (t0_req && !t0_hi) || (rb_req && !rb_hi) ||
      |(periph_req & ~periph_prio);
  end

  // core requests: only while vectoring is globally allowed
  assign irq_high = any_high && ctrl_main_r[irq_prio_pkg::MAIN_GIE];
  assign irq_low = any_low && ctrl_main_r[irq_prio_pkg::MAIN_GIE];

  // wake from sleep: external flags only for enables armed as sleep began; any enabled peripheral request also wakes
  assign wake = sleeping &&
    (|(ext_flag & armed_r) || |(periph_req));
  assign stack_top = depth_r == 5'h00 ? 21'h000000 :
    stack_mem[depth_r - 5'h01];
  assign stack_depth = depth_r;
  assign shadow_context = shadow_r;

  // control register next state; hardware set wins over software clear
  always_comb begin
    ctrl_main_nxt = ctrl_main_r;
    ctrl_second_nxt = ctrl_second_r;
    ctrl_third_nxt = ctrl_third_r;
    periph_irq_priority_one_nxt = periph_irq_priority_one_r;
    periph_irq_priority_two_nxt = periph_irq_priority_two_r;
    bus_ctrl_irq_priority_nxt = bus_ctrl_irq_priority_r;
    periph_flag_nxt = periph_flag_r;
    periph_en_nxt = periph_en_r;
    if (wr_main) ctrl_main_nxt = req.wdata;
    if (wr_second) ctrl_second_nxt = req.wdata;
    if (wr_third) ctrl_third_nxt = req.wdata;
    if (req.wr) begin
      case (req.addr)
        irq_prio_pkg::ADDR_PRIO_ONE: begin
          periph_irq_priority_one_nxt = req.wdata;
        end
        irq_prio_pkg::ADDR_PRIO_TWO: begin
          periph_irq_priority_two_nxt =
            req.wdata & irq_prio_pkg::PRIO_TWO_MASK;
        end
        irq_prio_pkg::ADDR_BUS_PRIO: begin
          bus_ctrl_irq_priority_nxt = req.wdata;
        end
        irq_prio_pkg::ADDR_PERIPH_FLAG: begin
          // upper sources have no port here; keep their flags
          periph_flag_nxt = {16'hffff, req.wdata} & periph_flag_r;
        end
        irq_prio_pkg::ADDR_PERIPH_EN: begin
          periph_en_nxt = {16'h0000, req.wdata};
        end
        default: begin
        end
      endcase
    end
    periph_flag_nxt = periph_flag_nxt | periph_flags_set;
    if (ext_edge[0]) ctrl_main_nxt[irq_prio_pkg::MAIN_E0IF] = 1'b1;
    for (int i = 1; i < irq_prio_pkg::N_EXT; i++) begin
      if (ext_edge[i]) begin
        ctrl_third_nxt[irq_prio_pkg::THR_IF_LO + i - 1] = 1'b1;
      end
    end
    if (t0_wrap) ctrl_main_nxt[irq_prio_pkg::MAIN_T0IF] = 1'b1;
    if (port_b_pins_change) begin
      ctrl_main_nxt[irq_prio_pkg::MAIN_PORT_CHANGE_FLAG] = 1'b1;
    end
  end

  // pin history and sleep arming
  always_comb begin
    ext_prev_nxt = ext_pins;
    port_b_pins_prev_nxt = port_b_pins;
    armed_nxt = armed_r;
    if (!sleeping) armed_nxt = ext_en;
    else if (!sleep_prev_r) armed_nxt = ext_en;
  end

  // readback
  always_comb begin
    rdata_nxt = 8'h00;
    if (req.rd) begin
      case (req.addr)
        irq_prio_pkg::ADDR_CTRL_MAIN: rdata_nxt = ctrl_main_r;
        irq_prio_pkg::ADDR_CTRL_SECOND: rdata_nxt = ctrl_second_r;
        irq_prio_pkg::ADDR_CTRL_THIRD: rdata_nxt = ctrl_third_r;
        irq_prio_pkg::ADDR_PRIO_ONE: rdata_nxt = periph_irq_priority_one_r;
        irq_prio_pkg::ADDR_PRIO_TWO: rdata_nxt = periph_irq_priority_two_r;
        irq_prio_pkg::ADDR_BUS_PRIO: rdata_nxt = bus_ctrl_irq_priority_r;
        irq_prio_pkg::ADDR_PERIPH_FLAG: rdata_nxt = periph_flag_r[7:0];
        irq_prio_pkg::ADDR_PERIPH_EN: rdata_nxt = periph_en_r[7:0];
        irq_prio_pkg::ADDR_STATUS: rdata_nxt = {3'h0, depth_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // context save on interrupt entry
  always_comb begin
    depth_nxt = depth_r;
    shadow_nxt = shadow_r;
    if (irq_ack) begin
      if (depth_r != 5'(DEPTH)) depth_nxt = depth_r + 5'h01;
      shadow_nxt = core_context;
    end
  end

  // register all state except the return stack array
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl_main_r <= irq_prio_pkg::RST_CTRL_MAIN;
      ctrl_second_r <= irq_prio_pkg::RST_CTRL_SECOND;
      ctrl_third_r <= irq_prio_pkg::RST_CTRL_THIRD;
      periph_irq_priority_one_r <= irq_prio_pkg::RST_PRIO;
      periph_irq_priority_two_r <= irq_prio_pkg::RST_PRIO &
        irq_prio_pkg::PRIO_TWO_MASK;
      bus_ctrl_irq_priority_r <= irq_prio_pkg::RST_PRIO;
      periph_flag_r <= 24'h000000;
      periph_en_r <= 24'h000000;
      ext_prev_r <= 4'h0;
      port_b_pins_prev_r <= 4'h0;
      armed_r <= 4'h0;
      sleep_prev_r <= 1'b0;
      rdata <= irq_prio_pkg::RST_ZERO;
      depth_r <= 5'h00;
      shadow_r <= '0;
    end else begin
      ctrl_main_r <= ctrl_main_nxt;
      ctrl_second_r <= ctrl_second_nxt;
      ctrl_third_r <= ctrl_third_nxt;
      periph_irq_priority_one_r <= periph_irq_priority_one_nxt;
      periph_irq_priority_two_r <= periph_irq_priority_two_nxt;
      bus_ctrl_irq_priority_r <= bus_ctrl_irq_priority_nxt;
      periph_flag_r <= periph_flag_nxt;
      periph_en_r <= periph_en_nxt;
      ext_prev_r <= ext_prev_nxt;
      port_b_pins_prev_r <= port_b_pins_prev_nxt;
      armed_r <= armed_nxt;
      sleep_prev_r <= sleeping;
      rdata <= rdata_nxt;
      depth_r <= depth_nxt;
      shadow_r <= shadow_nxt;
    end
  end

  // return stack array, no reset needed
  always_ff @(posedge clk_sys) begin
    if (irq_ack && depth_r != 5'(DEPTH)) begin
      stack_mem[depth_r] <= return_pc;
    end
  end
endmodule

/* bench/irq_core_model.sv */
module irq_core_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // requests and pacing
  input wire logic irq_high,
  input wire logic irq_low,
  input wire logic ack_en,
  input wire logic [1:0] lat,
  // entry side
  output logic irq_ack,
  output logic [20:0] return_pc,
  output irq_prio_pkg::context_s core_context
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_r;
  // take a request after lat cycles; context moves every cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_ack <= 1'b0;
      wait_r <= 2'h0;
      return_pc <= 21'h000100;
      core_context <= 24'h123456;
    end else begin
      return_pc <= return_pc + 21'h000003;
      core_context <= core_context + 24'h010203;
      irq_ack <= 1'b0;
      wait_r <= 2'h0;
      if (ack_en && (irq_high || irq_low) && !irq_ack) begin
        wait_r <= wait_r + 2'h1;
        irq_ack <= (wait_r == lat);
      end
    end
  end
endmodule

/* bench/irq_prio_checker.sv */
module irq_prio_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // register port
  input wire irq_prio_pkg::reg_req_s req,
  input wire logic [7:0] rdata,
  // core side
  input wire logic sleeping,
  input wire logic irq_ack,
  input wire logic [20:0] return_pc,
  input wire irq_prio_pkg::context_s core_context,
  input wire logic irq_high,
  input wire logic irq_low,
  input wire logic wake,
  input wire logic [20:0] stack_top,
  input wire logic [4:0] stack_depth,
  input wire irq_prio_pkg::context_s shadow_context
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_prio_two_zero: assert property (
    req.rd && req.addr == irq_prio_pkg::ADDR_PRIO_TWO
    |=> rdata[5:4] == 2'h0 && !rdata[7]) else $error("reserved bits set");
  a_bus_prio_rw: assert property (
    (req.wr && req.addr == irq_prio_pkg::ADDR_BUS_PRIO) ##1
    (req.rd && req.addr == irq_prio_pkg::ADDR_BUS_PRIO)
    |=> rdata == $past(req.wdata, 2)) else $error("bus prio readback");
  a_gie_gates: assert property (
    (req.rd && req.addr == irq_prio_pkg::ADDR_CTRL_MAIN) ##1 !rdata[7]
    |-> !irq_high && !irq_low) else $error("request without gie");
  a_ack_push: assert property (
    irq_ack && stack_depth != 5'h1f |=> stack_top == $past(return_pc)
    && stack_depth == $past(stack_depth) + 5'h01) else $error("no push");
  a_stack_sat: assert property (
    irq_ack && stack_depth == 5'h1f |=> stack_depth == 5'h1f)
    else $error("stack overrun");
  a_stack_hold: assert property (
    !irq_ack |=> $stable(stack_depth) && $stable(stack_top))
    else $error("stack moved");
  a_ack_shadow: assert property (
    irq_ack |=> shadow_context == $past(core_context))
    else $error("shadow copy");
  a_wake_asleep: assert property (
    !sleeping |-> !wake) else $error("wake while awake");
endmodule

bind irq_prio irq_prio_checker chk (.clk_sys(clk_sys), .resetn(resetn),
  .req(req), .rdata(rdata), .sleeping(sleeping), .irq_ack(irq_ack),
  .return_pc(return_pc), .core_context(core_context),
  .irq_high(irq_high), .irq_low(irq_low), .wake(wake),
  .stack_top(stack_top), .stack_depth(stack_depth),
  .shadow_context(shadow_context));

/* bench/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, resetn, timer_zero_tick, timer_zero_16bit, sleeping;
  logic ack_en, irq_ack, irq_high, irq_low, wake;
  logic [1:0] lat;
  logic [3:0] ext_pins, port_b_pins;
  logic [15:0] timer_zero_count_pair;
  logic [23:0] periph_set;
  logic [7:0] rdata;
  logic [20:0] return_pc, stack_top, last_pc;
  logic [4:0] stack_depth;
  irq_prio_pkg::reg_req_s req;
  irq_prio_pkg::context_s core_context, shadow_context, last_ctx;
  int miscompares, n_checks, n_ack;
  // rows: write flag, address, write data, expected read
  logic [20:0] rows [15] = '{21'h0_0_00_00, 21'h0_1_00_f5, 21'h0_2_00_c0,
    21'h0_3_00_ff, 21'h0_4_00_4f, 21'h0_5_00_ff, 21'h0_f_00_00,
    21'h1_4_ff_00, 21'h0_4_00_4f, 21'h1_5_5a_00, 21'h0_5_00_5a,
    21'h1_3_a5_00, 21'h1_f_77_00, 21'h0_3_00_a5, 21'h0_f_00_00};
  irq_prio dut (.clk_sys(clk_sys), .resetn(resetn), .req(req),
    .rdata(rdata), .ext_pins(ext_pins), .port_b_pins(port_b_pins),
    .timer_zero_count_pair(timer_zero_count_pair),
    .timer_zero_tick(timer_zero_tick), .timer_zero_16bit(timer_zero_16bit),
    .periph_flags_set(periph_set), .sleeping(sleeping), .irq_ack(irq_ack),
    .return_pc(return_pc), .core_context(core_context),
    .irq_high(irq_high), .irq_low(irq_low), .wake(wake),
    .stack_top(stack_top), .stack_depth(stack_depth),
    .shadow_context(shadow_context));
  irq_core_model core (.clk_sys(clk_sys), .resetn(resetn),
    .irq_high(irq_high), .irq_low(irq_low), .ack_en(ack_en), .lat(lat),
    .irq_ack(irq_ack), .return_pc(return_pc), .core_context(core_context));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // log each taken interrupt
  always @(posedge clk_sys) begin
    if (irq_ack === 1'b1) begin
      n_ack++;
      last_pc <= return_pc;
      last_ctx <= core_context;
    end
  end
  task give_verdict;
    if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task idle(input int n);
    req <= '0;
    repeat (n) @(posedge clk_sys);
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys);
    req <= '0;
    #1 chk(24'(rdata), 24'(e));
    @(posedge clk_sys);
  endtask
  // compare wake, high and low request levels
  task st(input logic [2:0] e);
    #1 chk(24'({wake, irq_high, irq_low}), 24'(e));
    @(posedge clk_sys);
  endtask
  task tick(input logic [15:0] c);
    req <= '0;
    timer_zero_count_pair <= c;
    timer_zero_tick <= 1'b1;
    @(posedge clk_sys);
    timer_zero_tick <= 1'b0;
    idle(2);
  endtask
  initial begin
    #500000;
    miscompares++;
    give_verdict;
  end
  initial begin
    {resetn, sleeping, ack_en, timer_zero_tick, timer_zero_16bit} = '0;
    {ext_pins, port_b_pins, timer_zero_count_pair, lat} = '0;
    req = '0;
    periph_set = '0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    foreach (rows[i]) begin
      if (rows[i][20]) wr(rows[i][19:16], rows[i][15:8]);
      else rd(rows[i][19:16], rows[i][7:0]);
    end
    wr(4'h0, 8'h90);
    idle(1);
    ext_pins[0] <= 1'b1;
    idle(3);
    st(3'b010);
    rd(4'h0, 8'h92);
    wr(4'h0, 8'h90);
    idle(1);
    st(3'b000);
    wr(4'h1, 8'h05);
    wr(4'h2, 8'h08);
    ext_pins[1] <= 1'b1;
    idle(3);
    st(3'b000);
    ext_pins[1] <= 1'b0;
    idle(3);
    st(3'b001);
    rd(4'h2, 8'h09);
    wr(4'h2, 8'h01);
    idle(1);
    st(3'b000);
    rd(4'h2, 8'h01);
    wr(4'h0, 8'ha0);
    tick(16'h00fe);
    rd(4'h0, 8'ha0);
    tick(16'h12ff);
    rd(4'h0, 8'ha4);
    st(3'b010);
    wr(4'h0, 8'ha0);
    timer_zero_16bit <= 1'b1;
    tick(16'h12ff);
    rd(4'h0, 8'ha0);
    tick(16'hffff);
    wr(4'h1, 8'h01);
    idle(1);
    st(3'b001);
    wr(4'h0, 8'h88);
    port_b_pins[2] <= 1'b1;
    idle(3);
    st(3'b010);
    rd(4'h0, 8'h89);
    wr(4'h0, 8'h10);
    sleeping <= 1'b1;
    idle(2);
    ext_pins[0] <= 1'b0;
    idle(3);
    st(3'b100);
    sleeping <= 1'b0;
    wr(4'h0, 8'h92);
    lat <= 2'h2;
    ack_en <= 1'b1;
    idle(12);
    ack_en <= 1'b0;
    idle(2);
    #1 chk(24'(stack_depth), 24'(n_ack));
    chk(24'(stack_top), 24'(last_pc));
    chk(shadow_context, last_ctx);
    @(posedge clk_sys);
    lat <= 2'h0;
    ack_en <= 1'b1;
    idle(80);
    ack_en <= 1'b0;
    idle(2);
    #1 chk(24'(stack_depth), 24'h00001f);
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    rd(4'h0, 8'h01);
    #1 chk(24'(stack_depth), 24'h000000);
    wr(4'h7, 8'h01);
    wr(4'h0, 8'h80);
    periph_set <= 24'h000001;
    idle(1);
    periph_set <= '0;
    idle(1);
    st(3'b010);
    wr(4'h3, 8'h00);
    idle(1);
    st(3'b001);
    wr(4'h6, 8'h00);
    idle(1);
    st(3'b000);
    give_verdict;
  end
endmodule
